// File: rtl/msq_defs.svh
// constants for the microprogram sequencer slice
// assumes inclusion by bare name from the slice module
`ifndef MSQ_DEFS_SVH
`define MSQ_DEFS_SVH

// source select codes, upper select bit is the msb
`define MSQ_SEL_COUNTER 2'h0
`define MSQ_SEL_LATCH   2'h1
`define MSQ_SEL_STACK   2'h2
`define MSQ_SEL_DIRECT  2'h3

// structure
`define MSQ_SLICE_W     4
`define MSQ_STACK_DEPTH 4

// reset values
`define MSQ_RST_WORD    4'h0
`define MSQ_RST_PTR     2'h0

`endif

// File: rtl/msq_pkg.sv
// types shared by the sequencer slice and its surroundings
// assumes nothing beyond a systemverilog compiler
package msq_pkg;

   typedef struct packed {
      logic source_select_hi;
      logic source_select_lo;
   } msq_select_type;

   typedef struct packed {
      logic stack_op_enable_n;
      logic stack_direction;
   } msq_stack_ctrl_type;

endpackage : msq_pkg

// File: rtl/msq_sequencer_slice.sv
// cascadable next-address slice: mux, branch latch, counter, stack
// assumes controls come from a microword register on the same clock
//
// Contract
// [RULE_01] four-bit slice, carries chain slices wider
// [RULE_02] four-input mux picks the next address
// [RULE_03] codes: 0 counter, 1 latch, 2 stack, 3 direct
// [RULE_04] latch loads on edge while load enable low
// [RULE_05] reduced option feeds latch from direct inputs
// [RULE_06] carry high: counter takes output plus one
// [RULE_07] carry low: counter reloads output unchanged
// [RULE_08] incrementer has carry in and carry out
// [RULE_09] carry out when carry in and all ones
// [RULE_10] pointer addresses last written stack word
// [RULE_11] push: pointer up, counter written to top
// [RULE_12] pop: top offered now, pointer down next edge
// [RULE_13] stack enable high: stack left unchanged
// [RULE_14] push and pop move only the pointer
// [RULE_15] four nesting levels, any push pop sequence
// [RULE_16] pointer wraps modulo four, no overflow flag
// [RULE_17] zero input forces outputs low
// [RULE_18] each output bit ORed with its force input
// [RULE_19] output enable high floats the address outputs
// [RULE_20] state changes only on rising clock edge; the code also clears its state asynchronously while reset_n is low
// [RULE_21] controller supplies select bits each cycle
`timescale 1ns/100ps
`include "msq_defs.svh"

module msq_sequencer_slice #(
   parameter int       SLICE_W            = `MSQ_SLICE_W,
   parameter int       STACK_DEPTH        = `MSQ_STACK_DEPTH,
   parameter bit       SHARED_LATCH_INPUT = 1'b0
) (
   input  wire logic                        clk,
   input  wire logic                        reset_n,
   input  wire msq_pkg::msq_select_type     source_select,
   input  wire msq_pkg::msq_stack_ctrl_type stack_ctrl,
   input  wire logic                        branch_latch_load_n,
   input  wire logic [SLICE_W-1:0]          latch_data_in,
   input  wire logic [SLICE_W-1:0]          jump_target_in,
   input  wire logic [SLICE_W-1:0]          bit_set_in,
   input  wire logic                        force_zero_n,
   input  wire logic                        addr_out_enable_n,
   input  wire logic                        carry_in,
   output logic      [SLICE_W-1:0]          next_addr_out,
   output logic                             next_addr_oe,
   output logic                             carry_out
);

   localparam int PTR_W = $clog2(STACK_DEPTH);

   // state
   logic [SLICE_W-1:0] branch_latch_q;
   logic [SLICE_W-1:0] branch_latch_d;
   logic [SLICE_W-1:0] sequence_counter_q;
   logic [SLICE_W-1:0] sequence_counter_d;
   logic [PTR_W-1:0]   stack_top_index_q;
   logic [PTR_W-1:0]   stack_top_index_d;
   logic [SLICE_W-1:0] stack_mem [STACK_DEPTH];

   // decode
   logic [1:0]         sel_code;
   logic               is_sel_counter;
   logic               is_sel_latch;
   logic               is_sel_stack;
   logic               is_sel_direct;
   logic               stack_push;
   logic               stack_pop;
   logic [SLICE_W-1:0] stack_top_word;
   logic [SLICE_W-1:0] latch_source;
   logic [SLICE_W-1:0] mux_word;
   logic [SLICE_W-1:0] forced_word;
   logic [SLICE_W:0]   inc_sum;

   // word plus carry, one bit wider for the chain
   function automatic logic [SLICE_W:0] incr_word(
      input logic [SLICE_W-1:0] word,
      input logic               cin
   );
      incr_word = {1'b0, word} + {{SLICE_W{1'b0}}, cin};
   endfunction : incr_word

   // pointer step, wraps at the stack depth
   function automatic logic [PTR_W-1:0] step_ptr(
      input logic [PTR_W-1:0] ptr,
      input logic             up,
      input logic             down
   );
      logic [PTR_W-1:0] one;
      one = {{(PTR_W-1){1'b0}}, 1'b1};
      if (up) begin
         step_ptr = ptr + one;
      end else if (down) begin
         step_ptr = ptr - one;
      end else begin
         step_ptr = ptr;
      end
   endfunction : step_ptr

   assign sel_code = {source_select.source_select_hi, source_select.source_select_lo};
   assign is_sel_counter = (sel_code == `MSQ_SEL_COUNTER);   // [RULE_03]
   assign is_sel_latch   = (sel_code == `MSQ_SEL_LATCH);     // [RULE_03]
   assign is_sel_stack   = (sel_code == `MSQ_SEL_STACK);     // [RULE_03]
   assign is_sel_direct  = (sel_code == `MSQ_SEL_DIRECT);    // [RULE_03]

   assign stack_push = ~stack_ctrl.stack_op_enable_n & stack_ctrl.stack_direction;  // [RULE_11]
   assign stack_pop  = ~stack_ctrl.stack_op_enable_n & ~stack_ctrl.stack_direction; // [RULE_12]

   // top word read in place, words never shift
   assign stack_top_word = stack_mem[stack_top_index_q];   // [RULE_10]

   assign latch_source = SHARED_LATCH_INPUT ? jump_target_in : latch_data_in;  // [RULE_05]

   assign mux_word = is_sel_counter ? sequence_counter_q :
                     is_sel_latch   ? branch_latch_q     :
                     is_sel_stack   ? stack_top_word     :
                                      jump_target_in;    // [RULE_02]

   // zero wins over the per-bit force
   assign forced_word = force_zero_n ? (mux_word | bit_set_in)  // [RULE_18]
                                     : {SLICE_W{1'b0}};         // [RULE_17]

   assign inc_sum = incr_word(forced_word, carry_in);   // [RULE_01] [RULE_08]

   assign branch_latch_d     = branch_latch_load_n ? branch_latch_q : latch_source;  // [RULE_04]
   assign sequence_counter_d = inc_sum[SLICE_W-1:0];    // [RULE_06] [RULE_07]
   assign stack_top_index_d  = step_ptr(stack_top_index_q, stack_push, stack_pop); // [RULE_16]

   // address path is combinational through the mux by nature
   assign next_addr_out = forced_word;
   assign next_addr_oe  = ~addr_out_enable_n;           // [RULE_19]
   assign carry_out     = inc_sum[SLICE_W];             // [RULE_09]

   always_ff @(posedge clk or negedge reset_n) begin     // [RULE_20]
      if (!reset_n) begin
         branch_latch_q     <= `MSQ_RST_WORD;
         sequence_counter_q <= `MSQ_RST_WORD;
         stack_top_index_q  <= `MSQ_RST_PTR;
      end else begin
         branch_latch_q     <= branch_latch_d;
         sequence_counter_q <= sequence_counter_d;
         stack_top_index_q  <= stack_top_index_d;    // [RULE_14]
      end
   end

   // push writes the return address at the new top only
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < STACK_DEPTH; i++) begin
            stack_mem[i] <= `MSQ_RST_WORD;
         end
      end else if (stack_push) begin
         stack_mem[stack_top_index_d] <= sequence_counter_q;   // [RULE_11] [RULE_15]
      end
   end

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   a_select_counter: assert property (   // [RULE_03]
      (is_sel_counter && force_zero_n)
      |-> next_addr_out == (sequence_counter_q | bit_set_in))
      else $error("counter source not on output");

   a_select_latch: assert property (   // [RULE_02]
      (is_sel_latch && force_zero_n)
      |-> next_addr_out == (branch_latch_q | bit_set_in))
      else $error("latch source not on output");

   a_select_stack_direct: assert property (   // [RULE_03]
      force_zero_n |->
      (is_sel_stack  -> next_addr_out == (stack_mem[stack_top_index_q] | bit_set_in)) &&
      (is_sel_direct -> next_addr_out == (jump_target_in | bit_set_in)))
      else $error("stack or direct source not on output");

   a_latch_load: assert property (   // [RULE_04]
      !branch_latch_load_n |=> branch_latch_q == $past(latch_source))
      else $error("latch missed its load");

   a_latch_hold: assert property (   // [RULE_20]
      branch_latch_load_n |=> $stable(branch_latch_q))
      else $error("latch changed without load");

   a_counter_step: assert property (   // [RULE_06]
      carry_in |=> sequence_counter_q == ($past(next_addr_out) + 1'b1))
      else $error("counter not output plus one");

   a_counter_repeat: assert property (   // [RULE_07]
      !carry_in |=> sequence_counter_q == $past(next_addr_out))
      else $error("counter not reloaded with output");

   a_carry_chain: assert property (   // [RULE_09]
      carry_out |-> carry_in && (next_addr_out == {SLICE_W{1'b1}}))
      else $error("carry out without overflow");

   a_push_top: assert property (   // [RULE_11]
      stack_push |=> stack_top_index_q == $past(stack_top_index_d)
                     && stack_top_word == $past(sequence_counter_q))
      else $error("push did not store return address");

   a_pop_ptr: assert property (   // [RULE_12]
      stack_pop
      |=> stack_top_index_q == $past(stack_top_index_q) - 1'b1)
      else $error("pop did not lower pointer");

   a_stack_idle: assert property (   // [RULE_13]
      stack_ctrl.stack_op_enable_n
      |=> $stable(stack_top_index_q) && $stable(stack_top_word))
      else $error("stack moved while disabled");

   a_ptr_wrap: assert property (   // [RULE_16]
      (stack_push && (&stack_top_index_q)) |=> stack_top_index_q == `MSQ_RST_PTR)
      else $error("pointer did not wrap");

   a_return_path: assert property (   // [RULE_15]
      stack_push ##1 (stack_pop && is_sel_stack && force_zero_n
                      && bit_set_in == {SLICE_W{1'b0}})
      |-> next_addr_out == $past(sequence_counter_q))
      else $error("one-word subroutine return wrong");

   a_zero_force: assert property (   // [RULE_17]
      !force_zero_n |-> next_addr_out == {SLICE_W{1'b0}} && !carry_out)
      else $error("zero input did not clear output");

   a_bit_force: assert property (   // [RULE_18]
      force_zero_n |-> (next_addr_out & bit_set_in) == bit_set_in)
      else $error("force input did not set bit");

   a_out_float: assert property (   // [RULE_19]
      addr_out_enable_n |-> !next_addr_oe)
      else $error("outputs driven while disabled");

   a_out_enable: assert property (   // [RULE_19]
      !addr_out_enable_n |-> next_addr_oe)
      else $error("outputs not driven while enabled");

   a_carry_low: assert property (   // [RULE_09]
      !carry_in |-> !carry_out)
      else $error("carry out without carry in");

   a_carry_full: assert property (   // [RULE_08]
      (carry_in && next_addr_out == {SLICE_W{1'b1}}) |-> carry_out)
      else $error("carry out missing on overflow");

   a_zero_over_bits: assert property (   // [RULE_17]
      (!force_zero_n && bit_set_in != {SLICE_W{1'b0}}) |-> next_addr_out == {SLICE_W{1'b0}})
      else $error("force input beat zero input");

   a_bits_only_set: assert property (   // [RULE_18]
      force_zero_n |-> (next_addr_out & ~bit_set_in) == (mux_word & ~bit_set_in))
      else $error("force input changed other bits");

   a_direct_source: assert property (   // [RULE_03]
      (is_sel_direct && force_zero_n && bit_set_in == {SLICE_W{1'b0}})
      |-> next_addr_out == jump_target_in)
      else $error("direct inputs not on output");

   a_zero_counter: assert property (   // [RULE_06]
      (!force_zero_n && carry_in)
      |=> sequence_counter_q == {{(SLICE_W-1){1'b0}}, 1'b1})
      else $error("counter not one after zero word");

   a_push_ptr_up: assert property (   // [RULE_11]
      stack_push |=> stack_top_index_q == $past(stack_top_index_q) + 1'b1)
      else $error("push did not raise pointer");

   a_push_keeps_old: assert property (   // [RULE_14]
      stack_push |=> stack_mem[$past(stack_top_index_q)] == $past(stack_top_word))
      else $error("push disturbed older word");

   a_pop_no_write: assert property (   // [RULE_14]
      stack_pop |=> stack_mem[$past(stack_top_index_q)] == $past(stack_top_word))
      else $error("pop changed a stored word");

   a_pop_wrap: assert property (   // [RULE_16]
      (stack_pop && stack_top_index_q == `MSQ_RST_PTR) |=> (&stack_top_index_q))
      else $error("pointer did not wrap on pop");

   a_stack_ref: assert property (   // [RULE_10]
      (is_sel_stack && stack_ctrl.stack_op_enable_n) |=> $stable(stack_top_index_q))
      else $error("stack reference moved pointer");

   c_pop_wrap: cover property (stack_pop && stack_top_index_q == `MSQ_RST_PTR);
   c_push_then_pop: cover property (stack_push ##1 stack_pop);
   c_four_deep: cover property (stack_push [*4]);
   c_carry_out: cover property (carry_out);
   c_latch_jump: cover property (!branch_latch_load_n ##1 is_sel_latch);

endmodule : msq_sequencer_slice

// File: verif/msq_ctrl_mem.sv
// control memory side of the slice: resolves the three-state address bus
// assumes the slice reports its drive through a high-active output enable
`timescale 1ns/100ps
module msq_ctrl_mem (
   input  wire logic [3:0] addr_drive,
   input  wire logic       addr_oe,
   input  wire logic [3:0] ext_addr,
   output logic      [3:0] addr_bus
);
   // external equipment takes the bus while the slice floats
   assign addr_bus = addr_oe ? addr_drive : ext_addr;
endmodule : msq_ctrl_mem

// File: verif/tb_top.sv
// directed testbench for the sequencer slice, driven as a microword register
// assumes the slice, its package and the control memory model compile first
`timescale 1ns/100ps
`include "msq_defs.svh"
module tb_top;
   logic       clk         = 1'b0;
   logic       reset_n     = 1'b0;
   logic [1:0] sel         = `MSQ_SEL_COUNTER;
   logic       fe_n        = 1'b1;
   logic       dir         = 1'b0;
   logic       load_n      = 1'b1;
   logic [3:0] lat         = 4'h0;
   logic [3:0] d           = 4'h0;
   logic [3:0] bits        = 4'h0;
   logic       zn          = 1'b1;
   logic       oen         = 1'b0;
   logic       cin         = 1'b1;
   logic [3:0] ext         = 4'h7;
   logic [3:0] y;
   logic       oe;
   logic       cout;
   logic [3:0] bus;
   logic [3:0] pops [5]    = '{4'hC, 4'hB, 4'hA, 4'h9, 4'hC};
   int         miscompares = 0;
   int         checks      = 0;

   always #5 clk = ~clk;

   msq_sequencer_slice dut (
      .clk                 (clk),
      .reset_n             (reset_n),
      .source_select       (msq_pkg::msq_select_type'(sel)),
      .stack_ctrl          (msq_pkg::msq_stack_ctrl_type'({fe_n, dir})),
      .branch_latch_load_n (load_n),
      .latch_data_in       (lat),
      .jump_target_in      (d),
      .bit_set_in          (bits),
      .force_zero_n        (zn),
      .addr_out_enable_n   (oen),
      .carry_in            (cin),
      .next_addr_out       (y),
      .next_addr_oe        (oe),
      .carry_out           (cout)
   );

   msq_ctrl_mem mem (
      .addr_drive (y),
      .addr_oe    (oe),
      .ext_addr   (ext),
      .addr_bus   (bus)
   );

   task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic at(input string what, input logic [3:0] exp);
      #1;
      chk(what, bus, exp);
   endtask : at

   task automatic tick;
      @(posedge clk);
      @(negedge clk);
   endtask : tick

   task automatic finish_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test

   initial begin
      #2000;
      miscompares++;
      finish_test;
   end

   initial begin
      repeat (3) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      at("reset counter", 4'h0);
      tick;
      at("increment", 4'h1);
      cin = 1'b0;
      tick;
      at("repeat", 4'h1);
      cin = 1'b1;
      load_n = 1'b0;
      lat = 4'h5;
      tick;
      load_n = 1'b1;
      lat = 4'h9;
      sel = `MSQ_SEL_LATCH;
      at("latch", 4'h5);
      tick;
      at("latch held", 4'h5);
      // five pushes: the fifth overwrites the oldest word
      sel = `MSQ_SEL_DIRECT;
      fe_n = 1'b0;
      dir = 1'b1;
      for (int i = 0; i < 5; i++) begin
         d = 4'h8 + 4'(i);
         at("direct", d);
         tick;
      end
      sel = `MSQ_SEL_STACK;
      fe_n = 1'b1;
      at("stack ref", 4'hC);
      tick;
      dir = 1'b0;
      at("no stack op", 4'hC);
      tick;
      fe_n = 1'b0;
      foreach (pops[i]) begin
         at("pop", pops[i]);
         tick;
      end
      fe_n = 1'b1;
      sel = `MSQ_SEL_DIRECT;
      d = 4'hF;
      #1 chk("carry", {3'h0, cout}, 4'h1);
      cin = 1'b0;
      #1 chk("no carry", {3'h0, cout}, 4'h0);
      cin = 1'b1;
      d = 4'hE;
      #1 chk("carry low word", {3'h0, cout}, 4'h0);
      bits = 4'h5;
      d = 4'h8;
      at("or force", 4'hD);
      zn = 1'b0;
      at("zero", 4'h0);
      tick;
      zn = 1'b1;
      bits = 4'h0;
      sel = `MSQ_SEL_COUNTER;
      at("after zero", 4'h1);
      oen = 1'b1;
      #1 chk("released", {3'h0, oe}, 4'h0);
      at("external", 4'h7);
      finish_test;
   end
endmodule : tb_top
